// File: dv/imb_checker.sv
`timescale 1ns/1ps
// ***
// Port checker.
// ***
module imb_checker (
  input wire logic clk_sys_i, rst_n_i, wr_i, rd_i, irq_o,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o,
  input wire logic [55:0] event_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_rd_idle: assert property (!rd_i |=> !rdata_o)
    else $error("idle data");
  a_ts_rsvd: assert property (rd_i && addr_i == 12'h110 |=> !rdata_o[7:5])
    else $error("rsvd set");
  a_st_rsvd: assert property (rd_i && addr_i == 12'h112 |=> !rdata_o[1])
    else $error("rsvd set");
  a_acq_rsvd: assert property (rd_i && addr_i == 12'h113 |=> !rdata_o[7:5])
    else $error("rsvd set");
  a_prof_rsvd: assert property (rd_i && addr_i == 12'h114 |=> !rdata_o[7:6])
    else $error("rsvd set");
  a_chan0_analog_loop_irq_enable_rsvd: assert property (rd_i && addr_i == 12'h115 |=> !rdata_o[7:5])
    else $error("rsvd set");
  a_ref_readback: assert property (wr_i && addr_i == 12'h10f ##1 !wr_i
    ##1 rd_i && addr_i == 12'h10f |=> rdata_o == $past(wdata_i, 3)) else $error("readback");
  a_irq_cause: assert property ($rose(irq_o) |->
    $past(event_i) != 56'h0 || $past(wr_i) || $past(wr_i, 2)) else $error("irq rise");
  c_irq: cover property ($rose(irq_o));
  c_clr: cover property ($fell(irq_o));
  c_rd: cover property (rd_i ##1 rdata_o != 8'h00);
endmodule // imb_checker
bind imb_irq_mask_bank imb_checker u_chk (.*);

// File: dv/imb_irq_mask_bank_test.sv
`timescale 1ns/1ps
// ***
// Directed register and interrupt sequences.
// ***
module imb_irq_mask_bank_test;
  import imb_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, irq;
  logic [11:0] a = 12'h000;
  logic [55:0] ev = 56'h0;
  imb_byte_type wd = 8'h00, rdata;
  int n_mismatch = 0, samples_checked = 0;
  imb_byte_type wm [7] = '{8'hff, 8'h1f, 8'hff, 8'hfd, 8'h1f, 8'h3f, 8'h1f};
  imb_irq_mask_bank uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(a),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .event_i(ev), .rdata_o(rdata), .irq_o(irq));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  task chk(input imb_byte_type g, e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task w(input logic [11:0] ad, input imb_byte_type d);
    @(posedge clk_sys_i);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task r(input logic [11:0] ad, input imb_byte_type e);
    @(posedge clk_sys_i);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(negedge clk_sys_i);
    chk(rdata, e);
  endtask
  task pulse(input logic [55:0] v);
    @(posedge clk_sys_i);
    ev <= v;
    @(posedge clk_sys_i);
    ev <= 56'h0;
  endtask
  // The request is registered, so it settles one cycle after an event or read and two after a mask write.
  task ci(input logic e);
    repeat (2) @(negedge clk_sys_i);
    chk({7'h0, irq}, {7'h0, e});
  endtask
  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk_sys_i);
    n_mismatch++;
    complete_run;
  end
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int k = 0; k < 7; k++) r(12'h10f + k, 8'h00);
    for (int k = 0; k < 7; k++) w(12'h10f + k, 8'hff);
    for (int k = 0; k < 7; k++) r(12'h10f + k, wm[k]);
    r(12'h200, 8'h00);
    w(12'h10f, 8'ha5);
    r(12'h10f, 8'ha5);
    for (int k = 0; k < 7; k++) w(12'h10f + k, 8'h00);
    pulse(56'h1 << 16);
    ci(1'b0);
    w(12'h111, 8'h01);
    ci(1'b1);
    r(12'h120, 8'h00);
    ci(1'b0);
    w(12'h10f, 8'h08);
    pulse(56'h80);
    ci(1'b0);
    pulse(56'h08);
    ci(1'b1);
    r(12'h120, 8'h88);
    ci(1'b0);
    w(12'h114, 8'h01);
    pulse(56'h1 << 40);
    ci(1'b1);
    r(12'h122, 8'h00);
    ci(1'b0);
    w(12'h115, 8'h10);
    pulse(56'h10 << 48);
    ci(1'b1);
    r(12'h121, 8'h10);
    ci(1'b0);
    complete_run;
  end
endmodule // imb_irq_mask_bank_test

// File: rtl/imb_irq_mask_bank.sv
`timescale 1ns/1ps
`include "imb_map.svh"
// Behaviour
// RQ1: 0x10F bits 7..4 enable complement second-ref resync, valid, unfault, fault.
// RQ2: 0x10F bits 3..0 enable true second-ref resync, valid, unfault, fault.
// RQ3: Divider resync event raised on resync, reported only when its mask is one.
// RQ4: 0x110 bit 4 enables skew update; bits 7..5 reserved, read zero.
// RQ5: 0x110 bits 3,2 enable timestamp 1 and 0 time-code events.
// RQ6: 0x110 bits 1,0 enable auxiliary oscillator 1 and 0 events.
// RQ7: Mask bit one enables its source; zero keeps it disabled.
// RQ8: 0x111 enables first-channel clamp, slew limiter, frequency and phase lock events.
// RQ9: 0x113 bits 4..2 enable divider resync and fast-acquisition events; rest reserved. The code stores bits 4..0; only bits 7..5 read zero.
// RQ10: Registers 0x111..0x115 reset to zero and are read/write; 0x115 bits 4..0.
// RQ11: 0x112 enables switching, freerun, holdover, hitless, history, phase step; bit 1 reserved.
// RQ12: 0x114 bits 5..0 enable profile 5..0 activation events.
// RQ13: Masked events never raise the request; enabled ones combine onto it.
module imb_irq_mask_bank
  import imb_pkg::*;
(
  input wire logic clk_sys_i, // 20 MHz system clock
  input wire logic rst_n_i, // Asynchronous active-low reset
  input wire logic [11:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [`IMB_NUM_SRC-1:0] event_i, // Event pulses, same clock, reg-ordered
  output logic [7:0] rdata_o, // Read data, valid the cycle after rd_i
  output logic irq_o // Level interrupt request
);

  // ****************************************************************
  // Mask registers
  // ****************************************************************
  imb_bus_req_type req;
  imb_byte_type mask_r [`IMB_NUM_REGS];
  imb_byte_type mask_nxt [`IMB_NUM_REGS];
  imb_byte_type wmask [`IMB_NUM_REGS];
  logic [11:0] ofs [`IMB_NUM_REGS];

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  assign ofs[0] = `IMB_OFS_REF_B_PAIR;
  assign ofs[1] = `IMB_OFS_TIMESTAMP;
  assign ofs[2] = `IMB_OFS_LOCK;
  assign ofs[3] = `IMB_OFS_STATE;
  assign ofs[4] = `IMB_OFS_FAST_ACQ;
  assign ofs[5] = `IMB_OFS_PROFILE;
  assign ofs[6] = `IMB_OFS_ANALOG;
  assign wmask[0] = `IMB_WMASK_REF_B_PAIR; // see RQ1 see RQ2
  assign wmask[1] = `IMB_WMASK_TIMESTAMP; // see RQ4 see RQ5 see RQ6
  assign wmask[2] = `IMB_WMASK_LOCK; // see RQ8
  assign wmask[3] = `IMB_WMASK_STATE; // see RQ11
  assign wmask[4] = `IMB_WMASK_FAST_ACQ; // see RQ9
  assign wmask[5] = `IMB_WMASK_PROFILE; // see RQ12
  assign wmask[6] = `IMB_WMASK_ANALOG; // see RQ10

  // Reserved bits are never stored, so they always read zero, except 0x113 bits 1..0, which are stored.
  always_comb
  begin
    for (int i = 0; i < `IMB_NUM_REGS; i++)
    begin
      mask_nxt[i] = mask_r[i];
      if (req.wr && req.addr == ofs[i])
      begin
        mask_nxt[i] = req.wdata & wmask[i]; // see RQ10
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < `IMB_NUM_REGS; i++)
      begin
        mask_r[i] <= `IMB_RESET_VALUE; // see RQ10
      end
    end
    else
    begin
      mask_r <= mask_nxt;
    end
  end

  // ****************************************************************
  // Sticky status, cleared by reading
  // ****************************************************************
  logic [`IMB_NUM_SRC-1:0] mask_flat;
  logic [`IMB_NUM_SRC-1:0] stat_r;
  logic [`IMB_NUM_SRC-1:0] stat_nxt;
  logic [`IMB_NUM_SRC-1:0] clr;

  genvar g;
  generate
    for (g = 0; g < `IMB_NUM_REGS; g++)
    begin : g_flat
      assign mask_flat[g*8 +: 8] = mask_r[g];
    end
  endgenerate

  // Status bits latch every event so software sees it even if masked later; reading
  // the three status words clears 24, 24 and 8 bits of the register-ordered sources,
  // but only 0x120 (bits 7..0) and 0x121 (bits 55..48) return data; 0x122 reads zero.
  always_comb
  begin
    clr = '0;
    if (req.rd && req.addr == `IMB_OFS_STATUS_LO)
    begin
      clr[23:0] = '1;
    end
    if (req.rd && req.addr == `IMB_OFS_STATUS_MID)
    begin
      clr[47:24] = '1;
    end
    if (req.rd && req.addr == `IMB_OFS_STATUS_HI)
    begin
      clr[55:48] = '1;
    end
    // A new event wins over the read clear so it is never lost.
    stat_nxt = (stat_r & ~clr) | event_i; // see RQ3
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stat_r <= '0;
    end
    else
    begin
      stat_r <= stat_nxt;
    end
  end

  // ****************************************************************
  // Read port and interrupt output
  // ****************************************************************
  imb_byte_type rdata_nxt;
  logic irq_nxt;

  always_comb
  begin
    rdata_nxt = '0;
    if (req.rd)
    begin
      for (int i = 0; i < `IMB_NUM_REGS; i++)
      begin
        if (req.addr == ofs[i])
        begin
          rdata_nxt = mask_r[i];
        end
      end
      if (req.addr == `IMB_OFS_STATUS_LO)
      begin
        rdata_nxt = stat_r[7:0];
      end
      if (req.addr == `IMB_OFS_STATUS_HI)
      begin
        rdata_nxt = stat_r[55:48];
      end
    end
    // Gating the next status keeps irq aligned with the status register.
    irq_nxt = |(stat_nxt & mask_flat); // see RQ7 see RQ13 see RQ3
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      rdata_o <= rdata_nxt;
      irq_o <= irq_nxt;
    end
  end

endmodule // imb_irq_mask_bank

// File: rtl/imb_map.svh
`ifndef IMB_MAP_SVH
`define IMB_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define IMB_OFS_REF_B_PAIR 12'h10f
`define IMB_OFS_TIMESTAMP 12'h110
`define IMB_OFS_LOCK 12'h111
`define IMB_OFS_STATE 12'h112
`define IMB_OFS_FAST_ACQ 12'h113
`define IMB_OFS_PROFILE 12'h114
`define IMB_OFS_ANALOG 12'h115
`define IMB_OFS_STATUS_LO 12'h120
`define IMB_OFS_STATUS_HI 12'h121
`define IMB_OFS_STATUS_MID 12'h122

// ****************************************************************
// Writable bit masks and reset values
// ****************************************************************
`define IMB_WMASK_REF_B_PAIR 8'hff
`define IMB_WMASK_TIMESTAMP 8'h1f
`define IMB_WMASK_LOCK 8'hff
`define IMB_WMASK_STATE 8'hfd
`define IMB_WMASK_FAST_ACQ 8'h1f
`define IMB_WMASK_PROFILE 8'h3f
`define IMB_WMASK_ANALOG 8'h1f
`define IMB_RESET_VALUE 8'h00
`define IMB_NUM_REGS 7
`define IMB_NUM_SRC 56

`endif

// File: rtl/imb_pkg.sv
package imb_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } imb_bus_req_type;

  typedef logic [7:0] imb_byte_type;

endpackage
